// [design/dsu_port.sv]
// One serial port: 8-bit register file, FIFOs, baud timing, line drivers.
// Assumes host strobes are synchronous one-cycle pulses on core_clk.
`timescale 1ns/1ps
`default_nettype none
module dsu_port
   import dsu_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset,
   input wire logic [9:0] io_addr,
   input wire logic io_rd,
   input wire logic io_wr,
   input wire logic [7:0] io_wdata,
   output logic [7:0] io_rdata,
   output logic io_sel,
   input wire logic [5:0] port_a_base_switch,
   input wire logic rs485_sel,
   input wire logic high_speed_sel,
   input wire logic [1:0] drv_mode_sel,
   input wire logic rxd_pin,
   input wire logic cts_pin,
   input wire logic dsr_pin,
   input wire logic dcd_pin,
   input wire logic ri_pin,
   output logic txd_pin,
   output logic txd_oe,
   output logic rts_pin,
   output logic dtr_pin,
   output logic irq
);
   logic [7:0] line_ctl_reg_r;
   logic [7:0] interrupt_enable_reg_r;
   logic [7:0] modem_ctl_reg_r;
   logic [7:0] scratch_r;
   logic [15:0] divisor_r;
   logic fifo_en_r;
   logic [1:0] trig_sel_r;
   logic [2:0] rx_s1_r, rx_s2_r;
   logic [3:0] ms_s1_r, ms_s2_r, ms_prev_r;
   logic [3:0] msr_delta_r;
   logic [7:0] rd_nxt;
   logic hit, dls, base_wr, base_rd;
   logic [2:0] ofs;
   // Host decode: A9 fixed high, A3..A8 from switch
   assign hit = io_addr[9] && (io_addr[8:3] == port_a_base_switch); // RULE_02
   assign ofs = io_addr[2:0];
   assign dls = line_ctl_reg_r[DSU_LCR_DLS]; // RULE_03
   assign base_wr = hit && io_wr;
   assign base_rd = hit && io_rd;
   logic [DSU_ACC_W-1:0] acc_r;
   logic tick_r;
   logic [15:0] divcnt_r;
   logic os_tick;
   // Base tick at 16x115200 (or 8x that), then divided by divisor
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         acc_r <= '0;
         tick_r <= 1'b0;
      end
      else
      begin
         {tick_r, acc_r} <= {1'b0, acc_r} +
            {1'b0, high_speed_sel ? DSU_STEP_8X : DSU_STEP_1X}; // RULE_17
      end
   end
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         divcnt_r <= 16'h0000;
      end
      else if (tick_r)
      begin
         divcnt_r <= (divcnt_r + 16'h0001 >= divisor_r) ? 16'h0000 :
            divcnt_r + 16'h0001; // RULE_07
      end
   end
   assign os_tick = tick_r && (divcnt_r + 16'h0001 >= divisor_r);
   // Transmit FIFO
   logic [4:0] tx_cnt_r, rx_cnt_r;
   logic [3:0] tx_wp_r, tx_rp_r, rx_wp_r, rx_rp_r;
   logic tx_push, tx_pop, rx_push, rx_pop, tx_clr, rx_clr;
   logic [10:0] tx_q, rx_q, rx_din;
   assign tx_clr = base_wr && ofs == DSU_OFS_FCR && io_wdata[DSU_FCR_TXCLR];
   assign rx_clr = base_wr && ofs == DSU_OFS_FCR && io_wdata[DSU_FCR_RXCLR];
   assign tx_push = base_wr && ofs == DSU_OFS_DATA && !dls &&
      tx_cnt_r != DSU_FIFO_DEPTH; // RULE_05
   always_ff @(posedge core_clk)
   begin
      if (reset || tx_clr) // RULE_09
      begin
         tx_wp_r <= 4'h0;
         tx_rp_r <= 4'h0;
         tx_cnt_r <= 5'h00;
      end
      else
      begin
         if (tx_push)
            tx_wp_r <= tx_wp_r + 4'h1;
         if (tx_pop)
            tx_rp_r <= tx_rp_r + 4'h1;
         tx_cnt_r <= tx_cnt_r + {4'h0, tx_push} - {4'h0, tx_pop};
      end
   end
   dsu_fifo_mem u_txmem (.core_clk(core_clk), .wr_en(tx_push),
      .wr_addr(tx_wp_r), .wr_data({3'h0, io_wdata}),
      .rd_addr(tx_rp_r + {3'h0, tx_pop}), .rd_data(tx_q));
   // Transmitter
   dsu_tx_t tx_st_r;
   logic [3:0] tx_ph_r;
   logic [2:0] tx_bit_r;
   logic [7:0] tx_sh_r;
   logic tx_line_r, tx_stop2_r, tx_busy;
   logic [2:0] wlen;
   logic par_bit;
   assign wlen = {1'b1, line_ctl_reg_r[1:0]};
   // Store read data lags a write into an empty queue by one cycle
   logic tx_fresh_r;
   always_ff @(posedge core_clk)
      tx_fresh_r <= !reset && tx_push && tx_cnt_r == 5'h00;
   assign tx_pop = tx_st_r == DSU_TX_IDLE && tx_cnt_r != 5'h00 && os_tick &&
      !tx_fresh_r;
   assign par_bit = line_ctl_reg_r[DSU_LCR_STICK] ?
      !line_ctl_reg_r[DSU_LCR_EVEN] :
      (^(tx_sh_r & ((8'hFF) >> (3'h7 - wlen)))) ^
      !line_ctl_reg_r[DSU_LCR_EVEN];
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         tx_st_r <= DSU_TX_IDLE;
         tx_ph_r <= 4'h0;
         tx_bit_r <= 3'h0;
         tx_sh_r <= 8'h00;
         tx_line_r <= 1'b1;
         tx_stop2_r <= 1'b0;
      end
      else if (os_tick)
      begin
         tx_ph_r <= tx_ph_r + 4'h1;
         case (tx_st_r)
            DSU_TX_IDLE:
            begin
               tx_ph_r <= 4'h0;
               tx_line_r <= 1'b1; // RULE_19
               if (tx_pop)
               begin
                  tx_sh_r <= tx_q[7:0];
                  tx_line_r <= 1'b0;
                  tx_st_r <= DSU_TX_START;
               end
            end
            DSU_TX_START:
            begin
               if (tx_ph_r == DSU_OVS_LAST)
               begin
                  tx_line_r <= tx_sh_r[0]; // RULE_19
                  tx_bit_r <= 3'h0;
                  tx_st_r <= DSU_TX_DATA;
               end
            end
            DSU_TX_DATA:
            begin
               if (tx_ph_r == DSU_OVS_LAST)
               begin
                  tx_bit_r <= tx_bit_r + 3'h1;
                  if (tx_bit_r == wlen)
                  begin
                     tx_line_r <= line_ctl_reg_r[DSU_LCR_PEN] ? par_bit :
                        1'b1;
                     tx_st_r <= line_ctl_reg_r[DSU_LCR_PEN] ? DSU_TX_PAR :
                        DSU_TX_STOP;
                     tx_stop2_r <= line_ctl_reg_r[DSU_LCR_STOP];
                  end
                  else
                  begin
                     tx_line_r <= tx_sh_r[tx_bit_r + 3'h1];
                  end
               end
            end
            DSU_TX_PAR:
            begin
               if (tx_ph_r == DSU_OVS_LAST)
               begin
                  tx_line_r <= 1'b1;
                  tx_st_r <= DSU_TX_STOP;
               end
            end
            DSU_TX_STOP:
            begin
               if (tx_ph_r == DSU_OVS_LAST)
               begin
                  tx_stop2_r <= 1'b0;
                  if (!tx_stop2_r)
                     tx_st_r <= DSU_TX_IDLE;
               end
            end
            default: tx_st_r <= DSU_TX_IDLE;
         endcase
      end
   end
   assign tx_busy = tx_st_r != DSU_TX_IDLE;
   // Receiver
   dsu_rx_t rx_st_r;
   logic [3:0] rx_ph_r;
   logic [2:0] rx_bit_r;
   logic [7:0] rx_sh_r;
   logic rx_perr_r, rx_push_r, rx_oe_r;
   logic [2:0] rx_flags_r;
   logic rxd;
   assign rxd = rx_s2_r[0];
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         rx_st_r <= DSU_RX_IDLE;
         rx_ph_r <= 4'h0;
         rx_bit_r <= 3'h0;
         rx_sh_r <= 8'h00;
         rx_perr_r <= 1'b0;
         rx_push_r <= 1'b0;
         rx_flags_r <= 3'h0;
      end
      else
      begin
         rx_push_r <= 1'b0;
         if (os_tick)
         begin
            rx_ph_r <= rx_ph_r + 4'h1;
            case (rx_st_r)
               DSU_RX_IDLE:
               begin
                  rx_ph_r <= 4'h0;
                  if (!rxd)
                     rx_st_r <= DSU_RX_START;
               end
               DSU_RX_START:
               begin
                  if (rx_ph_r == DSU_OVS_MID)
                  begin
                     rx_ph_r <= 4'h0;
                     rx_bit_r <= 3'h0;
                     rx_sh_r <= 8'h00;
                     rx_perr_r <= 1'b0;
                     rx_st_r <= rxd ? DSU_RX_IDLE : DSU_RX_DATA;
                  end
               end
               DSU_RX_DATA:
               begin
                  if (rx_ph_r == DSU_OVS_LAST)
                  begin
                     rx_sh_r[rx_bit_r] <= rxd; // RULE_19
                     rx_bit_r <= rx_bit_r + 3'h1;
                     if (rx_bit_r == wlen)
                        rx_st_r <= line_ctl_reg_r[DSU_LCR_PEN] ? DSU_RX_PAR :
                           DSU_RX_STOP;
                  end
               end
               DSU_RX_PAR:
               begin
                  if (rx_ph_r == DSU_OVS_LAST)
                  begin
                     rx_perr_r <= line_ctl_reg_r[DSU_LCR_STICK] ?
                        (rxd != !line_ctl_reg_r[DSU_LCR_EVEN]) :
                        ((^rx_sh_r) ^ rxd) != !line_ctl_reg_r[DSU_LCR_EVEN];
                     rx_st_r <= DSU_RX_STOP;
                  end
               end
               DSU_RX_STOP:
               begin
                  if (rx_ph_r == DSU_OVS_LAST)
                  begin
                     rx_push_r <= 1'b1;
                     rx_flags_r <= {!rxd && rx_sh_r == 8'h00, !rxd,
                        rx_perr_r};
                     rx_st_r <= DSU_RX_IDLE;
                  end
               end
               default: rx_st_r <= DSU_RX_IDLE;
            endcase
         end
      end
   end
   assign rx_push = rx_push_r && rx_cnt_r != DSU_FIFO_DEPTH;
   assign rx_din = {rx_flags_r, rx_sh_r};
   assign rx_pop = base_rd && ofs == DSU_OFS_DATA && !dls &&
      rx_cnt_r != 5'h00; // RULE_04
   always_ff @(posedge core_clk)
   begin
      if (reset || rx_clr) // RULE_09
      begin
         rx_wp_r <= 4'h0;
         rx_rp_r <= 4'h0;
         rx_cnt_r <= 5'h00;
      end
      else
      begin
         if (rx_push)
            rx_wp_r <= rx_wp_r + 4'h1;
         if (rx_pop)
            rx_rp_r <= rx_rp_r + 4'h1;
         rx_cnt_r <= rx_cnt_r + {4'h0, rx_push} - {4'h0, rx_pop};
      end
   end
   always_ff @(posedge core_clk)
   begin
      if (reset)
         rx_oe_r <= 1'b0;
      else if (rx_push_r && rx_cnt_r == DSU_FIFO_DEPTH)
         rx_oe_r <= 1'b1;
      else if (base_rd && ofs == DSU_OFS_LSR)
         rx_oe_r <= 1'b0;
   end
   dsu_fifo_mem u_rxmem (.core_clk(core_clk), .wr_en(rx_push),
      .wr_addr(rx_wp_r), .wr_data(rx_din),
      .rd_addr(rx_rp_r + {3'h0, rx_pop}), .rd_data(rx_q));
   // Registers
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         line_ctl_reg_r <= DSU_LCR_RST;
         interrupt_enable_reg_r <= 8'h00;
         modem_ctl_reg_r <= 8'h00;
         scratch_r <= 8'h00;
         divisor_r <= DSU_DIV_RST;
         fifo_en_r <= 1'b0;
         trig_sel_r <= 2'h0;
      end
      else if (base_wr)
      begin
         case (ofs)
            DSU_OFS_DATA:
               if (dls)
                  divisor_r[7:0] <= io_wdata; // RULE_06
            DSU_OFS_IER:
               if (dls)
                  divisor_r[15:8] <= io_wdata; // RULE_06
               else
                  interrupt_enable_reg_r <= io_wdata & DSU_IER_MASK; // RULE_08
            DSU_OFS_FCR:
            begin
               fifo_en_r <= io_wdata[DSU_FCR_EN]; // RULE_09
               trig_sel_r <= io_wdata[7:6]; // RULE_10
            end
            DSU_OFS_LCR: line_ctl_reg_r <= io_wdata; // RULE_11
            DSU_OFS_MCR: modem_ctl_reg_r <= io_wdata;
            DSU_OFS_SCR: scratch_r <= io_wdata;
            default: scratch_r <= scratch_r;
         endcase
      end
   end
   // Modem inputs sync and delta capture; set wins over read clear
   logic [3:0] ms_now;
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         rx_s1_r <= 3'h7;
         rx_s2_r <= 3'h7;
         ms_s1_r <= 4'h0;
         ms_s2_r <= 4'h0;
         ms_prev_r <= 4'h0;
         msr_delta_r <= 4'h0;
      end
      else
      begin
         rx_s1_r <= {2'h3, rxd_pin};
         rx_s2_r <= rx_s1_r;
         ms_s1_r <= {dcd_pin, ri_pin, dsr_pin, cts_pin};
         ms_s2_r <= ms_s1_r;
         ms_prev_r <= ms_now;
         msr_delta_r <= ((base_rd && ofs == DSU_OFS_MSR) ? 4'h0 : msr_delta_r)
            | (ms_now ^ ms_prev_r);
      end
   end
   // RS-422: set-ready and carrier-detect follow terminal-ready
   assign ms_now = rs485_sel ? ms_s2_r :
      {modem_ctl_reg_r[DSU_MCR_DTR], ms_s2_r[2],
      modem_ctl_reg_r[DSU_MCR_DTR], ms_s2_r[0]}; // RULE_15
   logic [4:0] trig;
   logic [7:0] line_state_reg;
   always_comb
   begin
      case (trig_sel_r)
         2'h0: trig = DSU_TRIG_1;
         2'h1: trig = DSU_TRIG_4;
         2'h2: trig = DSU_TRIG_8;
         default: trig = DSU_TRIG_14; // RULE_10
      endcase
   end
   always_comb
   begin
      line_state_reg = 8'h00;
      line_state_reg[DSU_LSR_DR] = rx_cnt_r != 5'h00; // RULE_18
      line_state_reg[DSU_LSR_OE] = rx_oe_r;
      line_state_reg[DSU_LSR_PE] = rx_cnt_r != 5'h00 && rx_q[8];
      line_state_reg[DSU_LSR_FE] = rx_cnt_r != 5'h00 && rx_q[9];
      line_state_reg[DSU_LSR_BI] = rx_cnt_r != 5'h00 && rx_q[10];
      line_state_reg[DSU_LSR_THRE] = tx_cnt_r == 5'h00; // RULE_18
      line_state_reg[DSU_LSR_TEMT] = tx_cnt_r == 5'h00 && !tx_busy;
      line_state_reg[DSU_LSR_FERR] = line_state_reg[DSU_LSR_PE] | line_state_reg[DSU_LSR_FE] |
         line_state_reg[DSU_LSR_BI];
   end
   always_comb
   begin
      case (ofs)
         DSU_OFS_DATA: rd_nxt = dls ? divisor_r[7:0] : rx_q[7:0]; // RULE_04
         DSU_OFS_IER: rd_nxt = dls ? divisor_r[15:8] : interrupt_enable_reg_r;
         DSU_OFS_FCR: rd_nxt = {fifo_en_r, fifo_en_r, 6'h00};
         DSU_OFS_LCR: rd_nxt = line_ctl_reg_r;
         DSU_OFS_MCR: rd_nxt = modem_ctl_reg_r;
         DSU_OFS_LSR: rd_nxt = line_state_reg;
         DSU_OFS_MSR: rd_nxt = {ms_now, msr_delta_r};
         default: rd_nxt = scratch_r;
      endcase
   end
   // Driver direction: no software handshake in auto mode
   logic oe_nxt, line_out;
   assign line_out = tx_line_r && !line_ctl_reg_r[DSU_LCR_BRK]; // RULE_11
   always_comb
   begin
      case (dsu_de_t'(drv_mode_sel))
         DSU_DE_RTS: oe_nxt = modem_ctl_reg_r[DSU_MCR_RTS]; // RULE_16
         DSU_DE_ON: oe_nxt = 1'b1;
         default: oe_nxt = rs485_sel ? (tx_busy || !line_out) : 1'b1;
      endcase
   end
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         io_rdata <= 8'h00;
         io_sel <= 1'b0;
         txd_pin <= 1'b1;
         txd_oe <= 1'b0;
         rts_pin <= 1'b0;
         dtr_pin <= 1'b0;
         irq <= 1'b0;
      end
      else
      begin
         io_rdata <= base_rd ? rd_nxt : 8'h00; // RULE_01
         io_sel <= base_rd;
         txd_pin <= line_out; // RULE_12
         txd_oe <= oe_nxt; // RULE_13 RULE_14
         rts_pin <= modem_ctl_reg_r[DSU_MCR_RTS];
         dtr_pin <= modem_ctl_reg_r[DSU_MCR_DTR];
         irq <= modem_ctl_reg_r[3] && (
            (interrupt_enable_reg_r[0] &&
               rx_cnt_r >= (fifo_en_r ? trig : DSU_TRIG_1)) ||
            (interrupt_enable_reg_r[1] && tx_cnt_r == 5'h00) ||
            (interrupt_enable_reg_r[2] && (rx_oe_r || line_state_reg[DSU_LSR_FERR])) ||
            (interrupt_enable_reg_r[3] && msr_delta_r != 4'h0));
      end
   end
endmodule
`default_nettype wire

// [design/dsu_pkg.sv]
// Constants for the dual serial port register block.
// Assumes an 8-bit host I/O bus with a switch-selected base address.
// Contract
// RULE_01: Every register is eight bits, bit zero least significant.
// RULE_02: Registers decode at fixed offsets from a switch-selected base.
// RULE_03: Line control bit seven steers offsets zero and one to divisor.
// RULE_04: Offset zero read returns oldest received character when select clear.
// RULE_05: Offset zero write queues a byte for transmission when select clear.
// RULE_06: With select set, offsets zero and one hold divisor low and high.
// RULE_07: Divisor one gives 115200 baud; larger divisors divide proportionally.
// RULE_08: Offset one holds four interrupt enable bits when select clear.
// RULE_09: FIFO control bit0 enables, bit1 flushes receive, bit2 flushes transmit.
// RULE_10: FIFO control bits seven and six set trigger 1, 4, 8 or 14.
// RULE_11: Line control holds word length, stops, parity, stick parity, break.
// RULE_12: RS-422 sends and receives on separate pairs simultaneously.
// RULE_13: RS-485 enables the shared driver only while transmitting.
// RULE_14: RS-485 direction switching is invisible to registers.
// RULE_15: RS-422 loops data-terminal-ready back to set-ready and carrier-detect.
// RULE_16: Request-to-send mode enables the driver only while that output high.
// RULE_17: High-speed option multiplies bit rate by eight.
// RULE_18: Line state bit0 flags data ready, bit5 transmit holding empty.
// RULE_19: Frame is low start, data lsb first, parity, high stops.
package dsu_pkg;
   localparam logic [2:0] DSU_OFS_DATA = 3'h0;
   localparam logic [2:0] DSU_OFS_IER = 3'h1;
   localparam logic [2:0] DSU_OFS_FCR = 3'h2;
   localparam logic [2:0] DSU_OFS_LCR = 3'h3;
   localparam logic [2:0] DSU_OFS_MCR = 3'h4;
   localparam logic [2:0] DSU_OFS_LSR = 3'h5;
   localparam logic [2:0] DSU_OFS_MSR = 3'h6;
   localparam logic [2:0] DSU_OFS_SCR = 3'h7;
   localparam int DSU_LCR_DLS = 7;
   localparam int DSU_LCR_BRK = 6;
   localparam int DSU_LCR_STICK = 5;
   localparam int DSU_LCR_EVEN = 4;
   localparam int DSU_LCR_PEN = 3;
   localparam int DSU_LCR_STOP = 2;
   localparam int DSU_FCR_EN = 0;
   localparam int DSU_FCR_RXCLR = 1;
   localparam int DSU_FCR_TXCLR = 2;
   localparam int DSU_LSR_DR = 0;
   localparam int DSU_LSR_OE = 1;
   localparam int DSU_LSR_PE = 2;
   localparam int DSU_LSR_FE = 3;
   localparam int DSU_LSR_BI = 4;
   localparam int DSU_LSR_THRE = 5;
   localparam int DSU_LSR_TEMT = 6;
   localparam int DSU_LSR_FERR = 7;
   localparam int DSU_MCR_DTR = 0;
   localparam int DSU_MCR_RTS = 1;
   localparam logic [7:0] DSU_IER_MASK = 8'h0F;
   localparam logic [15:0] DSU_DIV_RST = 16'h000C;
   localparam logic [7:0] DSU_LCR_RST = 8'h03;
   // Oversampling: 16 ticks per bit, base tick rate 16*115200
   localparam int DSU_CLK_HZ = 100000000;
   localparam int DSU_BASE_BAUD = 115200;
   localparam int DSU_OVS = 16;
   localparam int DSU_HS_MULT = 8;
   // Fixed-point accumulator step; 24-bit phase
   localparam int DSU_ACC_W = 24;
   localparam logic [DSU_ACC_W-1:0] DSU_STEP_1X = DSU_ACC_W'(
      (64'(DSU_BASE_BAUD) * DSU_OVS * (64'h1 << DSU_ACC_W)) / DSU_CLK_HZ);
   localparam logic [DSU_ACC_W-1:0] DSU_STEP_8X = DSU_ACC_W'(
      (64'(DSU_BASE_BAUD) * DSU_OVS * DSU_HS_MULT * (64'h1 << DSU_ACC_W))
      / DSU_CLK_HZ);
   localparam logic [3:0] DSU_OVS_MID = 4'h7;
   localparam logic [3:0] DSU_OVS_LAST = 4'hF;
   localparam int DSU_FIFO_AW = 4;
   localparam logic [4:0] DSU_FIFO_DEPTH = 5'h10;
   localparam logic [4:0] DSU_TRIG_1 = 5'h01;
   localparam logic [4:0] DSU_TRIG_4 = 5'h04;
   localparam logic [4:0] DSU_TRIG_8 = 5'h08;
   localparam logic [4:0] DSU_TRIG_14 = 5'h0E;
   typedef enum logic [1:0] {DSU_DE_AUTO, DSU_DE_RTS, DSU_DE_ON} dsu_de_t;
   typedef enum {DSU_TX_IDLE, DSU_TX_START, DSU_TX_DATA, DSU_TX_PAR,
      DSU_TX_STOP} dsu_tx_t;
   typedef enum {DSU_RX_IDLE, DSU_RX_START, DSU_RX_DATA, DSU_RX_PAR,
      DSU_RX_STOP} dsu_rx_t;
endpackage

// [design/dsu_fifo_mem.sv]
// Sixteen-entry 11-bit store (byte plus three flags) with registered read data.
// Assumes one write and one read port on core_clk.
`timescale 1ns/1ps
`default_nettype none
module dsu_fifo_mem
   import dsu_pkg::*;
(
   input wire logic core_clk,
   input wire logic wr_en,
   input wire logic [DSU_FIFO_AW-1:0] wr_addr,
   input wire logic [10:0] wr_data,
   input wire logic [DSU_FIFO_AW-1:0] rd_addr,
   output logic [10:0] rd_data
);
   logic [10:0] mem [0:15];
   always_ff @(posedge core_clk)
   begin
      if (wr_en)
      begin
         mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
   end
endmodule
`default_nettype wire

// [sim/dsu_port_sva.sv]
// Checker for the serial port's host strobes and line driver pins.
// Assumes one clock domain and the synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module dsu_port_sva
(
   input wire logic core_clk,
   input wire logic reset,
   input wire logic [9:0] io_addr,
   input wire logic io_rd,
   input wire logic io_wr,
   input wire logic [7:0] io_rdata,
   input wire logic io_sel,
   input wire logic [5:0] port_a_base_switch,
   input wire logic rs485_sel,
   input wire logic [1:0] drv_mode_sel,
   input wire logic txd_pin,
   input wire logic txd_oe,
   input wire logic rts_pin
);
   logic hit;
   logic rd_hit;
   assign hit = io_addr[9] && (io_addr[8:3] == port_a_base_switch);
   assign rd_hit = io_rd && hit;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (reset);
   AST_SEL_AFTER_READ: assert property (rd_hit |=> io_sel)
      else $error("io_sel missing after a matching read");
   AST_SEL_CAUSE: assert property (io_sel |-> $past(rd_hit))
      else $error("io_sel without a matching read");
   AST_RDATA_QUIET: assert property (!io_sel |-> io_rdata == 8'h00)
      else $error("io_rdata nonzero outside a read answer");
   AST_WRITE_SILENT: assert property (io_wr && !io_rd |=> !io_sel)
      else $error("write produced a read answer");
   AST_485_IDLE_HIGH: assert property (rs485_sel && drv_mode_sel == 2'h0
      && !txd_oe |-> txd_pin)
      else $error("line not idle high with driver off");
   AST_485_START_DRIVEN: assert property (rs485_sel && drv_mode_sel == 2'h0
      && $fell(txd_pin) |-> txd_oe)
      else $error("start bit sent with driver off");
   AST_RTS_ON: assert property ((drv_mode_sel == 2'h1 && rts_pin)[*3]
      |-> txd_oe)
      else $error("driver off while rts high");
   AST_RTS_OFF: assert property ((drv_mode_sel == 2'h1 && !rts_pin)[*3]
      |-> !txd_oe)
      else $error("driver on while rts low");
   AST_ALWAYS_ON: assert property ((drv_mode_sel == 2'h2)[*3]
      |-> txd_oe)
      else $error("driver off in always-on mode");
   AST_422_ON: assert property ((!rs485_sel && drv_mode_sel == 2'h0)[*3]
      |-> txd_oe)
      else $error("full duplex driver not enabled");
   cover property (rd_hit);
   cover property (rs485_sel && $fell(txd_pin));
   cover property (drv_mode_sel == 2'h1 && rts_pin && txd_oe);
endmodule
bind dsu_port dsu_port_sva dsu_port_sva_inst (.core_clk(core_clk),
   .reset(reset), .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr),
   .io_rdata(io_rdata), .io_sel(io_sel),
   .port_a_base_switch(port_a_base_switch), .rs485_sel(rs485_sel),
   .drv_mode_sel(drv_mode_sel), .txd_pin(txd_pin), .txd_oe(txd_oe),
   .rts_pin(rts_pin));
`default_nettype wire

// [sim/dsu_remote_node.sv]
// Remote terminal on the serial pairs: sends and captures frames.
// Assumes 8 data bits, no parity, one stop bit at the set bit time.
`timescale 1ns/1ps
`default_nettype none
module dsu_remote_node
#(
   parameter real BIT_NS = 1085.0694
)
(
   input wire logic txd_pin,
   input wire logic txd_oe,
   output logic rxd_pin
);
   logic [7:0] got_byte;
   logic got_stop;
   int got_count;
   initial
   begin
      rxd_pin = 1'b1;
      got_byte = 8'h00;
      got_stop = 1'b0;
      got_count = 0;
   end
   task automatic send_byte(input logic [7:0] b);
      rxd_pin = 1'b0;
      #(BIT_NS);
      for (int i = 0; i < 8; i++)
      begin
         rxd_pin = b[i];
         #(BIT_NS);
      end
      rxd_pin = 1'b1;
      #(BIT_NS);
   endtask
   // Own receiver runs regardless of our sending: full duplex
   always
   begin
      @(negedge txd_pin);
      #(BIT_NS * 1.5);
      for (int i = 0; i < 8; i++)
      begin
         got_byte[i] = txd_pin;
         #(BIT_NS);
      end
      // Undriven line cannot carry a valid stop
      got_stop = txd_pin && txd_oe;
      got_count++;
   end
endmodule
`default_nettype wire

// [sim/dsu_port_tb_top.sv]
// Self-checking bench for one serial port with a remote terminal model.
// Assumes base switch 0x3F, high speed on, divisor 1 after setup.
`timescale 1ns/1ps
`default_nettype none
module dsu_port_tb_top;
   localparam logic [9:0] BASE = 10'h3F8;
   logic core_clk, reset, io_rd, io_wr, io_sel, rs485_sel, high_speed_sel;
   logic rxd_pin, txd_pin, txd_oe, rts_pin, dtr_pin, irq;
   logic [9:0] io_addr;
   logic [7:0] io_wdata, io_rdata, d;
   logic [5:0] sw;
   logic [1:0] drv_mode_sel;
   logic [3:0] ms_in;
   logic s;
   int failures, samples_checked;
   initial
   begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   dsu_port dsu_port_inst (.core_clk(core_clk), .reset(reset),
      .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr), .io_wdata(io_wdata),
      .io_rdata(io_rdata), .io_sel(io_sel), .port_a_base_switch(sw),
      .rs485_sel(rs485_sel), .high_speed_sel(high_speed_sel),
      .drv_mode_sel(drv_mode_sel), .rxd_pin(rxd_pin), .cts_pin(ms_in[0]),
      .dsr_pin(ms_in[1]), .dcd_pin(ms_in[3]), .ri_pin(ms_in[2]),
      .txd_pin(txd_pin),
      .txd_oe(txd_oe), .rts_pin(rts_pin), .dtr_pin(dtr_pin), .irq(irq));
   dsu_remote_node dsu_remote_node_inst (.txd_pin(txd_pin),
      .txd_oe(txd_oe), .rxd_pin(rxd_pin));
   task automatic check(input string name, input logic [7:0] seen,
      input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         failures++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic rd(input logic [9:0] a);
      @(posedge core_clk);
      io_addr <= a;
      io_rd <= 1'b1;
      @(posedge core_clk);
      io_rd <= 1'b0;
      #1;
      d = io_rdata;
      s = io_sel;
   endtask
   task automatic wr(input logic [2:0] ofs, input logic [7:0] v);
      @(posedge core_clk);
      io_addr <= BASE | 10'(ofs);
      io_wdata <= v;
      io_wr <= 1'b1;
      @(posedge core_clk);
      io_wr <= 1'b0;
   endtask
   task automatic chk(input logic [2:0] ofs, input logic [7:0] v,
      input string name);
      rd(BASE | 10'(ofs));
      check(name, d, v);
   endtask
   task automatic wait_tx(input int n);
      for (int i = 0; i < 3000 && dsu_remote_node_inst.got_count < n; i++)
         @(posedge core_clk);
      check("frames", 8'(dsu_remote_node_inst.got_count), 8'(n));
   endtask
   task automatic t_registers;
      wr(3'h3, 8'h83);
      chk(3'h0, 8'h0C, "div_low");
      chk(3'h1, 8'h00, "div_high");
      chk(3'h3, 8'h83, "line_ctl");
      wr(3'h0, 8'h01);
      wr(3'h1, 8'h00);
      chk(3'h0, 8'h01, "div_low_new");
      wr(3'h3, 8'h03);
      wr(3'h1, 8'hFF);
      chk(3'h1, 8'h0F, "int_enables");
      wr(3'h1, 8'h00);
   endtask
   task automatic t_decode;
      rd(10'h2FD);
      check("foreign_sel", {7'h00, s}, 8'h00);
      rd(BASE | 10'h005);
      check("own_sel", {7'h00, s}, 8'h01);
   endtask
   task automatic t_transmit;
      wr(3'h0, 8'hA5);
      wait_tx(1);
      check("tx_byte", dsu_remote_node_inst.got_byte, 8'hA5);
      check("tx_stop", {7'h00, dsu_remote_node_inst.got_stop}, 8'h01);
      repeat (300) @(posedge core_clk);
      check("oe_idle", {7'h00, txd_oe}, 8'h00);
      rd(BASE | 10'h005);
      check("thr_empty", {7'h00, d[5]}, 8'h01);
   endtask
   task automatic t_receive;
      dsu_remote_node_inst.send_byte(8'h3C);
      repeat (20) @(posedge core_clk);
      rd(BASE | 10'h005);
      check("ready", {7'h00, d[0]}, 8'h01);
      wr(3'h2, 8'h03);
      rd(BASE | 10'h005);
      check("flushed", {7'h00, d[0]}, 8'h00);
      dsu_remote_node_inst.send_byte(8'hC3);
      repeat (20) @(posedge core_clk);
      chk(3'h0, 8'hC3, "rx_byte");
      rd(BASE | 10'h005);
      check("drained", {7'h00, d[0]}, 8'h00);
   endtask
   task automatic t_modes;
      @(posedge core_clk);
      rs485_sel <= 1'b0;
      ms_in <= 4'h1;
      wr(3'h4, 8'h01);
      repeat (5) @(posedge core_clk);
      rd(BASE | 10'h006);
      check("loopback", {5'h00, d[7], d[5], d[4]}, 8'h07);
      check("dtr", {7'h00, dtr_pin}, 8'h01);
      check("oe_422", {7'h00, txd_oe}, 8'h01);
      fork
         dsu_remote_node_inst.send_byte(8'h5A);
         wr(3'h0, 8'h96);
      join
      wait_tx(2);
      check("duplex_tx", dsu_remote_node_inst.got_byte, 8'h96);
      chk(3'h0, 8'h5A, "duplex_rx");
      drv_mode_sel <= 2'h1;
      wr(3'h4, 8'h03);
      repeat (5) @(posedge core_clk);
      check("oe_rts_on", {7'h00, txd_oe}, 8'h01);
      wr(3'h4, 8'h01);
      repeat (5) @(posedge core_clk);
      check("oe_rts_off", {7'h00, txd_oe}, 8'h00);
      drv_mode_sel <= 2'h2;
      repeat (5) @(posedge core_clk);
      check("oe_on", {7'h00, txd_oe}, 8'h01);
   endtask
   task automatic wrap_up;
      $display("Checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial
   begin
      #500000;
      failures++;
      wrap_up;
   end
   initial
   begin
      failures = 0;
      samples_checked = 0;
      reset = 1'b1;
      io_addr = 10'h000;
      io_rd = 1'b0;
      io_wr = 1'b0;
      io_wdata = 8'h00;
      sw = 6'h3F;
      rs485_sel = 1'b1;
      high_speed_sel = 1'b1;
      drv_mode_sel = 2'h0;
      ms_in = 4'h0;
      repeat (6) @(posedge core_clk);
      reset <= 1'b0;
      t_registers;
      t_decode;
      t_transmit;
      t_receive;
      t_modes;
      wrap_up;
   end
endmodule
`default_nettype wire
